// File: src/upconv_cfg_pkg.sv
// constants shared by the upconverter profile and configuration block
package upconv_cfg_pkg;

  // ====================================================================
  // register map
  localparam int        REG_COUNT      = 26;
  localparam logic [4:0] CTRL0_ADDR    = 5'h00;
  localparam logic [4:0] CTRL1_ADDR    = 5'h01;
  localparam logic [4:0] PROF_BASE     = 5'h02;
  localparam logic [4:0] PROF_STRIDE   = 5'h06;
  localparam logic [4:0] PROF_TW0      = 5'h00;
  localparam logic [4:0] PROF_TW1      = 5'h01;
  localparam logic [4:0] PROF_TW2      = 5'h02;
  localparam logic [4:0] PROF_TW3      = 5'h03;
  localparam logic [4:0] PROF_OPT      = 5'h04;
  localparam logic [4:0] PROF_GAIN     = 5'h05;

  // ====================================================================
  // field positions
  localparam int CTRL0_SEP_BIT     = 7;
  localparam int CTRL0_LSB_BIT     = 6;
  localparam int CTRL0_MULT_HI     = 5;
  localparam int CTRL0_MULT_LO     = 1;
  localparam int CTRL1_DBL_BIT     = 7;
  localparam int CTRL1_CONT_BIT    = 6;
  localparam int CTRL1_SLEEP_BIT   = 5;
  localparam int CTRL1_TONE_BIT    = 4;
  localparam int CTRL1_SINC_BIT    = 3;
  localparam int CTRL1_MBYP_BIT    = 2;
  localparam int CTRL1_FMT_HI      = 1;
  localparam int CTRL1_FMT_LO      = 0;
  localparam int OPT_RATE_HI       = 7;
  localparam int OPT_RATE_LO       = 2;
  localparam int OPT_INV_BIT       = 1;
  localparam int OPT_HB3_BIT       = 0;

  // ====================================================================
  // encodings and limits
  localparam logic [1:0] FMT_FULL    = 2'h2;
  localparam logic [1:0] FMT_HALF    = 2'h1;
  localparam logic [1:0] FMT_QUARTER = 2'h0;
  localparam logic [5:0] RATE_MIN    = 6'h02;
  localparam logic [4:0] MULT_UNITY  = 5'h01;

  // ====================================================================
  // reset values, index 25 down to 0
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    {12{8'h00}}, 8'h00, 8'h1e, 8'h80, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h04, 8'h06, 8'h15};

  // ====================================================================
  // gain pin shifter timing
  localparam int          AMP_HALF_BIT_NS  = 1000;
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          AMP_DIV_INT      = (AMP_HALF_BIT_NS + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  localparam logic [3:0]  AMP_DIV_CYCLES   = 4'(AMP_DIV_INT);
  localparam logic [4:0]  AMP_BITS_STEPS   = 5'h10;
  localparam logic [4:0]  AMP_LATCH_STEP   = 5'h11;

endpackage : upconv_cfg_pkg

// File: src/upconverter_profile_config.sv
// register bank, profile select, data assembler and carrier phase for the upconverter
`timescale 1ns/100ps

module upconverter_profile_config
  import upconv_cfg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [1:0]  profile_sel_in,
  input  wire logic        transmit_enable_in,
  input  wire logic [11:0] data_in,
  input  wire logic        iq_ready_in,
  output logic             iq_valid_out,
  output logic      [11:0] i_out,
  output logic      [11:0] q_out,
  output logic             data_ready_out,
  output logic      [31:0] phase_out,
  output logic             separate_out_line_select_out,
  output logic             lsb_first_out,
  output logic      [4:0]  clock_mult_out,
  output logic             clock_mult_bypass_out,
  output logic             interp_double_gain_out,
  output logic             continuous_mode_out,
  output logic             sinc_bypass_out,
  output logic             single_tone_out,
  output logic             asleep_out,
  output logic      [5:0]  interp_rate_out,
  output logic             invert_out,
  output logic             hb3_bypass_out,
  output logic             amp_clk_out,
  output logic             amp_data_out,
  output logic             amp_latch_out
);
  import upconv_cfg_pkg::*;

  // ====================================================================
  // state
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic [7:0]                rdata;
    logic [31:0]               act_tw;
    logic [5:0]                act_rate;
    logic                      act_inv;
    logic                      act_hb3;
    logic [7:0]                act_gain;
    logic                      tx_d;
    logic [8:0]                cnt;
    logic [8:0]                low_cnt;
    logic [1:0]                piece;
    logic                      comp_q;
    logic [11:0]               acc;
    logic [11:0]               i_hold;
    logic [1:0]                fill;
    logic [1:0][23:0]          fifo;
    logic                      valid;
    logic                      ready;
    logic [31:0]               phase;
    logic                      asleep;
    logic [7:0]                amp_sent;
    logic [7:0]                amp_shift;
    logic [4:0]                amp_step;
    logic                      amp_busy;
    logic [3:0]                amp_div;
    logic                      amp_clk;
    logic                      amp_data;
    logic                      amp_latch;
    logic [4:0]                clk_mult;
  } state_type;

  state_type   st_r;
  state_type   st_nxt;
  logic [4:0]  sel_base;
  logic [5:0]  rate_eff;
  logic [8:0]  period;
  logic [1:0]  last_piece;
  logic [1:0]  fmt;
  logic        cont_mode;
  logic        burst_zero;
  logic        tick;
  logic        run;
  logic        is_q;
  logic [11:0] piece_val;
  logic [11:0] word;
  logic        word_done;
  logic        push;
  logic        pop;

  // ====================================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // register port; unmapped reads give zero, unmapped writes vanish
    if (reg_wr_in && (int'(reg_addr_in) < REG_COUNT)) begin
      st_nxt.regs[reg_addr_in] = reg_wdata_in;
    end
    if (reg_rd_in) begin
      st_nxt.rdata = (int'(reg_addr_in) < REG_COUNT) ? st_r.regs[reg_addr_in] : 8'h00;
    end
    // the analog multiplier sees unity while bypassed, whatever the field holds
    st_nxt.clk_mult = st_nxt.regs[CTRL1_ADDR][CTRL1_MBYP_BIT]
                      ? MULT_UNITY
                      : st_nxt.regs[CTRL0_ADDR][CTRL0_MULT_HI:CTRL0_MULT_LO];

    // whole profile captured from one select value in one edge
    sel_base = 5'(PROF_BASE + PROF_STRIDE * {3'h0, profile_sel_in});
    st_nxt.act_tw   = {st_r.regs[5'(sel_base + PROF_TW3)],
                       st_r.regs[5'(sel_base + PROF_TW2)],
                       st_r.regs[5'(sel_base + PROF_TW1)],
                       st_r.regs[5'(sel_base + PROF_TW0)]};
    st_nxt.act_rate = st_r.regs[5'(sel_base + PROF_OPT)][OPT_RATE_HI:OPT_RATE_LO];
    st_nxt.act_inv  = st_r.regs[5'(sel_base + PROF_OPT)][OPT_INV_BIT];
    st_nxt.act_hb3  = st_r.regs[5'(sel_base + PROF_OPT)][OPT_HB3_BIT];
    st_nxt.act_gain = st_r.regs[5'(sel_base + PROF_GAIN)];

    // input sample period in clocks; rates below the minimum would stall the counter
    fmt       = st_r.regs[CTRL1_ADDR][CTRL1_FMT_HI:CTRL1_FMT_LO];
    cont_mode = st_r.regs[CTRL1_ADDR][CTRL1_CONT_BIT];
    rate_eff  = (st_r.act_rate < RATE_MIN) ? RATE_MIN : st_r.act_rate;
    if (fmt == FMT_QUARTER) begin
      period = {3'h0, rate_eff};
    end else if (st_r.act_hb3) begin
      period = {2'h0, rate_eff, 1'b0};
    end else begin
      period = {1'h0, rate_eff, 2'h0};
    end
    case (fmt)
      FMT_HALF:    last_piece = 2'h1;
      FMT_QUARTER: last_piece = 2'h3;
      default:     last_piece = 2'h0;
    endcase

    // sample strobe, restarted half a period after each rising enable
    st_nxt.tx_d = transmit_enable_in;
    if (transmit_enable_in && !st_r.tx_d) begin
      // one less than half, so the first sample lands mid window even at period two
      st_nxt.cnt    = {1'b0, period[8:1]} - 9'h001;
      st_nxt.piece  = 2'h0;
      st_nxt.comp_q = 1'b0;
      tick          = 1'b0;
    end else if (st_r.cnt == 9'h000) begin
      st_nxt.cnt = period - 9'h001;
      tick       = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt - 9'h001;
      tick       = 1'b0;
    end
    if (transmit_enable_in) begin
      st_nxt.low_cnt = 9'h000;
    end else if (st_r.low_cnt != 9'h1ff) begin
      st_nxt.low_cnt = st_r.low_cnt + 9'h001;
    end
    burst_zero = !cont_mode && (st_r.low_cnt > period);

    // data assembly
    run = !st_r.regs[CTRL1_ADDR][CTRL1_TONE_BIT]
          && !st_r.regs[CTRL1_ADDR][CTRL1_SLEEP_BIT];
    if (burst_zero) begin
      piece_val = 12'h000;
    end else begin
      piece_val = data_in;
    end
    // continuous timing: enable high marks i, low marks q; assumes full words
    is_q = cont_mode ? !transmit_enable_in : st_r.comp_q;
    case (fmt)
      FMT_HALF:    word = {st_r.acc[5:0], piece_val[11:6]};
      FMT_QUARTER: word = {st_r.acc[8:0], piece_val[11:9]};
      default:     word = piece_val;
    endcase
    word_done = run && tick && (st_r.piece == last_piece);
    push      = word_done && is_q;
    if (run && tick) begin
      st_nxt.acc   = word;
      st_nxt.piece = word_done ? 2'h0 : st_r.piece + 2'h1;
    end
    if (word_done) begin
      st_nxt.comp_q = !is_q;
      if (!is_q) begin
        st_nxt.i_hold = word;
      end
    end

    // two-entry buffer; a pair arriving while full is dropped and ready shows it
    pop = st_r.valid && iq_ready_in;
    if (pop) begin
      st_nxt.fifo[0] = st_r.fifo[1];
      st_nxt.fill    = st_r.fill - 2'h1;
    end
    if (push && ((st_r.fill != 2'h2) || pop)) begin
      st_nxt.fifo[st_nxt.fill[0]] = {st_r.i_hold, word};
      st_nxt.fill                 = st_nxt.fill + 2'h1;
    end
    st_nxt.valid = (st_nxt.fill != 2'h0);
    st_nxt.ready = (st_nxt.fill != 2'h2);

    // carrier phase, frozen only once fully asleep
    if (!st_r.asleep) begin
      st_nxt.phase = st_r.phase + st_r.act_tw;
    end

    // shutdown sequence: intake stops, buffer drains, gain shift ends, then sleep
    st_nxt.asleep = st_r.regs[CTRL1_ADDR][CTRL1_SLEEP_BIT]
                    && (st_r.fill == 2'h0) && !st_r.amp_busy;

    // gain byte shifted msb first over clock, data and latch pins
    if (st_r.amp_div == 4'h0) begin
      st_nxt.amp_div = AMP_DIV_CYCLES - 4'h1;
      if (!st_r.amp_busy) begin
        // no new shift once sleep is asked for, so sleep can settle
        if ((st_r.act_gain != st_r.amp_sent)
            && !st_r.regs[CTRL1_ADDR][CTRL1_SLEEP_BIT]) begin
          st_nxt.amp_busy  = 1'b1;
          st_nxt.amp_shift = st_r.act_gain;
          st_nxt.amp_sent  = st_r.act_gain;
          st_nxt.amp_step  = 5'h00;
        end
      end else if (st_r.amp_step < AMP_BITS_STEPS) begin
        st_nxt.amp_clk  = st_r.amp_step[0];
        st_nxt.amp_data = st_r.amp_shift[7];
        if (st_r.amp_step[0]) begin
          st_nxt.amp_shift = {st_r.amp_shift[6:0], 1'b0};
        end
        st_nxt.amp_step = st_r.amp_step + 5'h01;
      end else if (st_r.amp_step < AMP_LATCH_STEP) begin
        st_nxt.amp_clk   = 1'b0;
        st_nxt.amp_latch = 1'b1;
        st_nxt.amp_step  = st_r.amp_step + 5'h01;
      end else begin
        st_nxt.amp_latch = 1'b0;
        st_nxt.amp_busy  = 1'b0;
      end
    end else begin
      st_nxt.amp_div = st_r.amp_div - 4'h1;
    end
  end

  // ====================================================================
  // registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r          <= '0;
      st_r.regs     <= REG_RESET;
      st_r.act_rate <= RATE_MIN;
      st_r.ready    <= 1'b1;
      st_r.clk_mult <= MULT_UNITY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ====================================================================
  // outputs, all straight from state flops
  assign reg_rdata_out                = st_r.rdata;
  assign iq_valid_out                 = st_r.valid;
  assign i_out                        = st_r.fifo[0][23:12];
  assign q_out                        = st_r.fifo[0][11:0];
  assign data_ready_out               = st_r.ready;
  assign phase_out                    = st_r.phase;
  assign separate_out_line_select_out = st_r.regs[CTRL0_ADDR][CTRL0_SEP_BIT];
  assign lsb_first_out                = st_r.regs[CTRL0_ADDR][CTRL0_LSB_BIT];
  assign clock_mult_out               = st_r.clk_mult;
  assign clock_mult_bypass_out        = st_r.regs[CTRL1_ADDR][CTRL1_MBYP_BIT];
  assign interp_double_gain_out       = st_r.regs[CTRL1_ADDR][CTRL1_DBL_BIT];
  assign continuous_mode_out          = st_r.regs[CTRL1_ADDR][CTRL1_CONT_BIT];
  assign sinc_bypass_out              = st_r.regs[CTRL1_ADDR][CTRL1_SINC_BIT];
  assign single_tone_out              = st_r.regs[CTRL1_ADDR][CTRL1_TONE_BIT];
  assign asleep_out                   = st_r.asleep;
  assign interp_rate_out              = st_r.act_rate;
  assign invert_out                   = st_r.act_inv;
  assign hb3_bypass_out               = st_r.act_hb3;
  assign amp_clk_out                  = st_r.amp_clk;
  assign amp_data_out                 = st_r.amp_data;
  assign amp_latch_out                = st_r.amp_latch;

  // ====================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_mult_bypass;
    reg_wr_in && (reg_addr_in == CTRL1_ADDR) && reg_wdata_in[CTRL1_MBYP_BIT]
      |=> clock_mult_out == MULT_UNITY;
  endproperty
  a_mult_bypass: assert property (p_mult_bypass) else $error("bypass gave non-unity");

  property p_mult_value;
    reg_wr_in && (reg_addr_in == CTRL0_ADDR) && !clock_mult_bypass_out
      && !(reg_wr_in && reg_addr_in == CTRL1_ADDR)
      |=> clock_mult_out == $past(reg_wdata_in[CTRL0_MULT_HI:CTRL0_MULT_LO]);
  endproperty
  a_mult_value: assert property (p_mult_value) else $error("multiplier field lost");

  property p_serial_cfg;
    reg_wr_in && (reg_addr_in == CTRL0_ADDR)
      |=> separate_out_line_select_out == $past(reg_wdata_in[CTRL0_SEP_BIT])
          && lsb_first_out == $past(reg_wdata_in[CTRL0_LSB_BIT]);
  endproperty
  a_serial_cfg: assert property (p_serial_cfg) else $error("serial config not taken");

  property p_phase_step;
    !asleep_out |=> phase_out == $past(phase_out) + $past(st_r.act_tw);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase step wrong");

  // profile lookup for the check below, kept apart from the capture logic
  logic [4:0] chk_base;
  assign chk_base = PROF_BASE + PROF_STRIDE * {3'h0, profile_sel_in};

  property p_profile_together;
    $changed(profile_sel_in) && !reg_wr_in
      |=> st_r.act_tw == {st_r.regs[5'($past(chk_base) + PROF_TW3)],
                          st_r.regs[5'($past(chk_base) + PROF_TW2)],
                          st_r.regs[5'($past(chk_base) + PROF_TW1)],
                          st_r.regs[5'($past(chk_base) + PROF_TW0)]}
          && st_r.act_gain == st_r.regs[5'($past(chk_base) + PROF_GAIN)]
          && {interp_rate_out, invert_out, hb3_bypass_out}
             == st_r.regs[5'($past(chk_base) + PROF_OPT)];
  endproperty
  a_profile_together: assert property (p_profile_together) else $error("mixed profile");

  property p_tone_no_data;
    single_tone_out |-> !push;
  endproperty
  a_tone_no_data: assert property (p_tone_no_data) else $error("data taken in tone mode");

  property p_zero_feed;
    burst_zero && run && tick |-> piece_val == 12'h000;
  endproperty
  a_zero_feed: assert property (p_zero_feed) else $error("pin data during idle burst");

  property p_sleep_quiet;
    asleep_out |-> !iq_valid_out && !st_r.amp_busy ##1 $stable(phase_out);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity while asleep");

  property p_resync;
    transmit_enable_in && !st_r.tx_d
      |=> st_r.cnt == {1'b0, $past(period[8:1])} - 9'h001;
  endproperty
  a_resync: assert property (p_resync) else $error("no resync on enable rise");

  property p_full_ready;
    iq_valid_out && !iq_ready_in ##1 iq_valid_out && !iq_ready_in && st_r.fill == 2'h2
      |-> !data_ready_out;
  endproperty
  a_full_ready: assert property (p_full_ready) else $error("ready while full");

  c_pair_out:  cover property (iq_valid_out && iq_ready_in);
  c_sleep:     cover property ($rose(asleep_out));
  c_amp_latch: cover property ($rose(amp_latch_out));
  c_zeros:     cover property (burst_zero && tick && run);

endmodule : upconverter_profile_config

// File: dv/baseband_source.sv
// baseband word source and pair consumer facing the upconverter data port
`timescale 1ns/100ps

module baseband_source (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        go_in,
  input  wire logic [3:0]  pairs_in,
  input  wire logic [2:0]  pieces_in,
  input  wire logic [7:0]  period_in,
  input  wire logic [11:0] base_in,
  input  wire logic        stall_in,
  output logic             transmit_enable_out,
  output logic      [11:0] data_out,
  output logic             iq_ready_out,
  output logic             busy_out
);
  // ====================
  // burst sequencing
  int          tick;
  int          piece;
  logic [11:0] word;

  assign iq_ready_out = !stall_in;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      transmit_enable_out <= 1'b0;
      data_out            <= 12'h000;
      busy_out            <= 1'b0;
      tick = 0;
      piece = 0;
    end else if (go_in && !busy_out) begin
      busy_out            <= 1'b1;
      transmit_enable_out <= 1'b1;
      data_out            <= base_in;
      tick = 0;
      piece = 0;
    end else if (busy_out) begin
      tick = tick + 1;
      if (tick == int'(period_in)) begin
        tick = 0;
        piece = piece + 1;
        if (piece == 2 * int'(pairs_in) * int'(pieces_in)) begin
          busy_out            <= 1'b0;
          transmit_enable_out <= 1'b0;
          data_out            <= ~data_out;
        end else begin
          // even words i, odd words q; each piece held a whole sample period
          word = base_in + 12'(piece / int'(pieces_in));
          data_out <= word << ((piece % int'(pieces_in)) * (12 / int'(pieces_in)));
        end
      end
    end else begin
      // released bus keeps changing so a stale word can never look valid
      data_out <= ~data_out;
    end
  end
endmodule : baseband_source

// File: dv/testbench.sv
// self-checking bench for the upconverter profile and configuration block
`timescale 1ns/100ps

module testbench;
  import upconv_cfg_pkg::*;
  // ====================
  // signals
  logic        clk_in, reset_n_in, reg_wr_in, reg_rd_in, transmit_enable_in, iq_ready_in;
  logic [4:0]  reg_addr_in, clock_mult_out;
  logic [7:0]  reg_wdata_in, reg_rdata_out, rv, v, amp_sh, amp_word;
  logic [1:0]  profile_sel_in;
  logic [11:0] data_in, i_out, q_out, base, bb;
  logic [31:0] phase_out, ph;
  logic [5:0]  interp_rate_out;
  logic        iq_valid_out, data_ready_out, separate_out_line_select_out, lsb_first_out;
  logic        clock_mult_bypass_out, interp_double_gain_out, continuous_mode_out;
  logic        sinc_bypass_out, single_tone_out, asleep_out, invert_out, hb3_bypass_out;
  logic        amp_clk_out, amp_data_out, amp_latch_out, go, stall, busy;
  logic [3:0]  pairs;
  logic [2:0]  pc;
  logic [7:0]  per;
  logic [23:0] popped[$];
  logic [5:0]  prate[4] = '{6'h02, 6'h3f, 6'h24, 6'h11};
  logic [7:0]  gain[4]  = '{8'ha5, 8'h5a, 8'hc3, 8'h3c};
  logic [1:0]  fmts[3]  = '{2'h2, 2'h1, 2'h0};
  int          cb[5]    = '{2, 3, 4, 6, 7};
  int          n_mismatch = 0, tests_run = 0, full_cycles = 0;
  int          n0, idx, j, k, f0, z;

  upconverter_profile_config dut_u (
    .clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .profile_sel_in, .transmit_enable_in, .data_in, .iq_ready_in, .iq_valid_out, .i_out,
    .q_out, .data_ready_out, .phase_out, .separate_out_line_select_out, .lsb_first_out,
    .clock_mult_out, .clock_mult_bypass_out, .interp_double_gain_out, .continuous_mode_out,
    .sinc_bypass_out, .single_tone_out, .asleep_out, .interp_rate_out, .invert_out,
    .hb3_bypass_out, .amp_clk_out, .amp_data_out, .amp_latch_out);

  baseband_source src_u (
    .clk_in, .reset_n_in, .go_in(go), .pairs_in(pairs), .pieces_in(pc), .period_in(per),
    .base_in(base), .stall_in(stall), .transmit_enable_out(transmit_enable_in),
    .data_out(data_in), .iq_ready_out(iq_ready_in), .busy_out(busy));

  // ====================
  // clock and monitors
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (reset_n_in && iq_valid_out && iq_ready_in) popped.push_back({i_out, q_out});
    if (!data_ready_out) full_cycles++;
  end
  always @(posedge amp_clk_out) amp_sh <= {amp_sh[6:0], amp_data_out};
  always @(posedge amp_latch_out) amp_word <= amp_sh;

  // ====================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    step(1);
    rv = reg_rdata_out;
  endtask : rd

  task automatic burst(input logic [3:0] np, input logic [2:0] npc, input logic [7:0] p,
                       input logic [11:0] b);
    int w;
    @(posedge clk_in);
    {pairs, pc, per, base, go} <= {np, npc, p, b, 1'b1};
    @(posedge clk_in);
    go <= 1'b0;
    step(1);
    for (w = 0; w < 2000 && busy !== 1'b0; w++) step(1);
  endtask : burst

  // search only pops since n0; earlier traffic may hold zero pairs
  task automatic seek(input logic [11:0] b);
    idx = -1;
    for (int m = n0; m < popped.size(); m++) if (idx < 0 && popped[m][23:12] === b) idx = m;
  endtask : seek

  function automatic logic [31:0] tw_of(input int p);
    return {8'h80 | 8'(p), 8'h41, 8'h20 + 8'(p), 8'h13};
  endfunction : tw_of

  task automatic report_and_stop;
    $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    report_and_stop();
  end

  // ====================
  // test sequence
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, go, stall} = 5'h10;
    {reg_addr_in, reg_wdata_in, profile_sel_in, pairs, pc, per, base} = '0;
    #1 reset_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    step(2);
    check(clock_mult_out, 32'h1);
    for (j = 0; j < REG_COUNT; j++) begin
      rd(5'(j));
      check(rv, REG_RESET[j]);
    end
    rd(CTRL0_ADDR);
    check(rv[5:1], 5'h0a);
    for (j = 2; j < 32; j++) wr(5'(j), 8'(j * 29 + 7));
    for (j = 2; j < 32; j++) begin
      rd(5'(j));
      check(rv, j < REG_COUNT ? 8'(j * 29 + 7) : 8'h00);
    end
    wr(CTRL1_ADDR, 8'h02);
    wr(CTRL0_ADDR, 8'h89);
    step(2);
    check({separate_out_line_select_out, lsb_first_out, clock_mult_out}, {2'b10, 5'h04});
    wr(CTRL0_ADDR, 8'h69);
    step(2);
    check({separate_out_line_select_out, lsb_first_out, clock_mult_out}, {2'b01, 5'h14});
    for (j = 0; j < 5; j++) begin
      v = 8'h02 | (8'h01 << cb[j]);
      wr(CTRL1_ADDR, v);
      step(2);
      check({interp_double_gain_out, continuous_mode_out, single_tone_out, sinc_bypass_out,
             clock_mult_bypass_out, clock_mult_out},
            {v[7], v[6], v[4], v[3], v[2], v[2] ? 5'h01 : 5'h14});
    end
    wr(CTRL1_ADDR, 8'h02);
    for (j = 0; j < 4; j++) begin
      for (k = 0; k < 4; k++) wr(PROF_BASE + 5'(6 * j + k), 8'(tw_of(j) >> (8 * k)));
      wr(PROF_BASE + 5'(6 * j) + PROF_OPT, {prate[j], 2'(j)});
      wr(PROF_BASE + 5'(6 * j) + PROF_GAIN, gain[j]);
    end
    for (j = 3; j >= 0; j--) begin
      @(posedge clk_in);
      profile_sel_in <= 2'(j);
      step(3);
      check({interp_rate_out, invert_out, hb3_bypass_out}, {prate[j], 2'(j)});
      ph = phase_out;
      step(1);
      check(phase_out - ph, tw_of(j));
      for (k = 0; k < 600 && amp_word !== gain[j]; k++) step(1);
      check(amp_word, gain[j]);
    end
    wr(CTRL1_ADDR, 8'h22);
    for (k = 0; k < 1000 && asleep_out !== 1'b1; k++) step(1);
    ph = phase_out;
    step(5);
    check(asleep_out, 1'b1);
    check(phase_out, ph);
    wr(CTRL1_ADDR, 8'h02);
    step(3);
    check(asleep_out, 1'b0);
    // profile zero: rate 2, third half-band in, so a piece lasts 8 clocks (2 in quarter)
    for (j = 0; j < 3; j++) begin
      bb = 12'h1a3 + 12'(j * 273);
      wr(CTRL1_ADDR, 8'(fmts[j]));
      n0 = popped.size();
      burst(4'h3, 3'(1 << j), j == 2 ? 8'h02 : 8'h08, bb);
      step(80);
      seek(bb);
      for (k = 0; k < 3; k++)
        check(popped[idx + k], {bb + 12'(2 * k), bb + 12'(2 * k + 1)});
      z = 0;
      for (k = idx + 3; k < idx + 9; k++) if (popped[k] === 24'h0) z = 1;
      check(z, 1);
    end
    wr(CTRL1_ADDR, 8'h02);
    n0 = popped.size();
    f0 = full_cycles;
    @(posedge clk_in);
    stall <= 1'b1;
    burst(4'h3, 3'h1, 8'h08, 12'h5c0);
    step(20);
    @(posedge clk_in);
    stall <= 1'b0;
    step(20);
    seek(12'h5c0);
    check(popped[idx], 24'h5c05c1);
    check(full_cycles > f0, 1'b1);
    z = 0;
    for (k = n0; k < popped.size(); k++) if (popped[k] === 24'h5c45c5) z = 1;
    check(z, 0);
    wr(CTRL1_ADDR, 8'h12);
    n0 = popped.size();
    burst(4'h2, 3'h1, 8'h08, 12'h7e1);
    step(20);
    seek(12'h7e1);
    check(idx, -1);
    report_and_stop();
  end
endmodule : testbench
